//--- src/adcsq_cfg.svh
// Purpose: offsets, field positions and reset values of the scan sequencer
// Assumes: 32-bit AXI4-Lite data, 8-bit byte address
// Notes:   every register is one aligned word
`ifndef ADCSQ_CFG_SVH
`define ADCSQ_CFG_SVH
// ****************************************
// register byte offsets, and address bits [7:6] of the result window
// ****************************************
`define ADCSQ_CTRL_OFS 8'h00
`define ADCSQ_CHSEL_OFS 8'h04
`define ADCSQ_PFM_OFS 8'h08
`define ADCSQ_PFT_OFS 8'h0c
`define ADCSQ_STAT_OFS 8'h10
`define ADCSQ_MASK_OFS 8'h14
`define ADCSQ_RES_BASE 2'h1
// ****************************************
// field positions
// ****************************************
`define ADCSQ_CTRL_EN_BIT 0
`define ADCSQ_CTRL_MODE_LO 1
`define ADCSQ_CTRL_MODE_HI 2
`define ADCSQ_CTRL_BUSY_BIT 3
`define ADCSQ_PFM_EN_BIT 0
`define ADCSQ_PFM_COND_BIT 1
// ****************************************
// reset values and bus answers
// ****************************************
`define ADCSQ_RST_BYTE 8'h00
`define ADCSQ_RST_CHAN 4'h0
`define ADCSQ_RESP_OKAY 2'h0
`define ADCSQ_RESP_SLVERR 2'h2
`endif

//--- src/adcsq_pkg.sv
// Purpose: types shared by the scan sequencer
// Assumes: nothing
// Notes:   gray coded states along idle, start, wait
package adcsq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_START = 2'h1,
        ST_WAIT = 2'h3,
        ST_HALT = 2'h2
    } adcsq_state_e;
endpackage

//--- src/adcsq_top.sv
// Purpose: channel sequencing, result storage and power-fail irq gating
// Assumes: front end runs on aclk, so conv_done and conv_data are unsynchronised
// Notes:   mode 00 cont select, 01 cont scan, 10 one-shot select, 11 one-shot scan
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "adcsq_cfg.svh"
module adcsq_top #(
    parameter int NCH = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog front end
    output logic conv_start,
    output logic [3:0] conv_chan,
    input wire logic conv_done,
    input wire logic [9:0] conv_data,
    // interrupt
    output logic irq
);
    // ****************************************
    // registers and state
    // ****************************************
    logic conversion_enable_bit;
    logic [1:0] op_mode;
    logic [3:0] channel_select_reg;
    logic powerfail_enable_bit;
    logic powerfail_condition_bit;
    logic [7:0] powerfail_threshold_reg;
    logic stat_end;
    logic mask_end;
    logic [9:0] chan_result_reg [NCH];
    adcsq_pkg::adcsq_state_e state;
    logic match0;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;

    // ****************************************
    // bus write side
    // ****************************************
    logic wr_fire;
    logic wr_hit;
    logic lane0;
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign lane0 = wr_fire && ws[0];

    // address and data are taken in either order, then one write fires
    // readies start high: both low with no response pending means a write is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCSQ_RESP_OKAY;
            wa <= `ADCSQ_RST_BYTE;
            wd <= 32'h0;
            ws <= 4'h0;
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wa <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd <= s_axi_wdata;
                ws <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (!s_axi_awready && s_axi_wready && !s_axi_wvalid && wa == 8'hff) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // result registers accept writes silently; only the six control registers at 0x00 to 0x14 are writable
    always_comb begin
        unique case (wa)
            `ADCSQ_CTRL_OFS, `ADCSQ_CHSEL_OFS, `ADCSQ_PFM_OFS,
            `ADCSQ_PFT_OFS, `ADCSQ_STAT_OFS, `ADCSQ_MASK_OFS: wr_hit = 1'b1;
            default: wr_hit = (wa[7:6] == `ADCSQ_RES_BASE);
        endcase
    end

    // control: enable and the two-bit operation mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conversion_enable_bit <= 1'b0;
            op_mode <= 2'h0;
        end else if (lane0 && wa == `ADCSQ_CTRL_OFS) begin
            conversion_enable_bit <= wd[`ADCSQ_CTRL_EN_BIT];
            op_mode <= wd[`ADCSQ_CTRL_MODE_HI:`ADCSQ_CTRL_MODE_LO];
        end
    end

    // channel select and power-fail setup
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_select_reg <= `ADCSQ_RST_CHAN;
            powerfail_enable_bit <= 1'b0;
            powerfail_condition_bit <= 1'b0;
            powerfail_threshold_reg <= `ADCSQ_RST_BYTE;
            mask_end <= 1'b0;
        end else if (lane0) begin
            if (wa == `ADCSQ_CHSEL_OFS) begin
                channel_select_reg <= wd[3:0];
            end
            if (wa == `ADCSQ_PFM_OFS) begin
                powerfail_enable_bit <= wd[`ADCSQ_PFM_EN_BIT];
                powerfail_condition_bit <= wd[`ADCSQ_PFM_COND_BIT];
            end
            if (wa == `ADCSQ_PFT_OFS) begin
                powerfail_threshold_reg <= wd[7:0];
            end
            if (wa == `ADCSQ_MASK_OFS) begin
                mask_end <= wd[0];
            end
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    logic scan_mode;
    logic one_shot;
    logic done_fire;
    logic last_ch;
    logic [7:0] upper;
    logic cmp_hit;
    logic end_event;
    assign scan_mode = op_mode[0];
    assign one_shot = op_mode[1];
    assign done_fire = (state == adcsq_pkg::ST_WAIT) && conversion_enable_bit && conv_done;
    // a shrunken select mid-scan still ends the pass, hence >=
    assign last_ch = !scan_mode || (conv_chan >= channel_select_reg);
    assign upper = conv_data[9:2];
    assign cmp_hit = powerfail_condition_bit ? (upper < powerfail_threshold_reg)
                                             : (upper >= powerfail_threshold_reg);
    // scans judge the whole pass by the channel 0 compare
    assign end_event = done_fire && last_ch && (!powerfail_enable_bit ||
        ((scan_mode && conv_chan != 4'h0) ? match0 : cmp_hit));

    // channel walk: select converts one channel, scan walks up from 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= adcsq_pkg::ST_IDLE;
            conv_chan <= `ADCSQ_RST_CHAN;
        end else begin
            unique case (state)
                adcsq_pkg::ST_IDLE: begin
                    if (conversion_enable_bit) begin
                        state <= adcsq_pkg::ST_START;
                        conv_chan <= scan_mode ? 4'h0 : channel_select_reg;
                    end
                end
                adcsq_pkg::ST_START: begin
                    state <= adcsq_pkg::ST_WAIT;
                end
                adcsq_pkg::ST_WAIT: begin
                    if (!conversion_enable_bit) begin
                        state <= adcsq_pkg::ST_IDLE;
                    end else if (conv_done) begin
                        if (last_ch && one_shot) begin
                            state <= adcsq_pkg::ST_HALT;
                        end else if (last_ch) begin
                            state <= adcsq_pkg::ST_START;
                            conv_chan <= scan_mode ? 4'h0 : channel_select_reg;
                        end else begin
                            state <= adcsq_pkg::ST_START;
                            conv_chan <= conv_chan + 4'h1;
                        end
                    end
                end
                adcsq_pkg::ST_HALT: begin
                    // stays stopped until software clears and sets enable
                    if (!conversion_enable_bit) begin
                        state <= adcsq_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // start strobe lags the start state by one edge, channel already stable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= (state == adcsq_pkg::ST_START);
        end
    end

    // channel 0 compare result held for the end of the scan pass
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match0 <= 1'b0;
        end else if (done_fire && conv_chan == 4'h0) begin
            match0 <= cmp_hit;
        end
    end

    // every completion in the wait state with enable set is stored, compare or not, at its own index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NCH; i++) begin
                chan_result_reg[i] <= 10'h000;
            end
        end else if (done_fire) begin
            chan_result_reg[conv_chan] <= conv_data;
        end
    end

    // ****************************************
    // interrupt
    // ****************************************
    // sticky end flag: a new event wins over a same-cycle write of one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_end <= 1'b0;
        end else begin
            stat_end <= end_event || (stat_end &&
                !(lane0 && wa == `ADCSQ_STAT_OFS && wd[0]));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= stat_end && mask_end;
        end
    end

    // ****************************************
    // bus read side
    // ****************************************
    logic [31:0] next_rdata;
    logic rd_hit;
    always_comb begin
        next_rdata = 32'h0;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `ADCSQ_CTRL_OFS: begin
                next_rdata[`ADCSQ_CTRL_EN_BIT] = conversion_enable_bit;
                next_rdata[`ADCSQ_CTRL_MODE_HI:`ADCSQ_CTRL_MODE_LO] = op_mode;
                next_rdata[`ADCSQ_CTRL_BUSY_BIT] = state[0];
            end
            `ADCSQ_CHSEL_OFS: next_rdata[3:0] = channel_select_reg;
            `ADCSQ_PFM_OFS: next_rdata[1:0] = {powerfail_condition_bit,
                                               powerfail_enable_bit};
            `ADCSQ_PFT_OFS: next_rdata[7:0] = powerfail_threshold_reg;
            `ADCSQ_STAT_OFS: next_rdata[0] = stat_end;
            `ADCSQ_MASK_OFS: next_rdata[0] = mask_end;
            default: begin
                rd_hit = (s_axi_araddr[7:6] == `ADCSQ_RES_BASE);
                if (rd_hit) begin
                    next_rdata[9:0] = chan_result_reg[s_axi_araddr[5:2]];
                end
            end
        endcase
    end

    // one read at a time; data answered the edge after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ADCSQ_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_hit ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_start_chan_range: assert property (
        conv_start && scan_mode |-> conv_chan <= channel_select_reg)
        else $error("scan channel beyond selected channel");
    a_result_store: assert property (
        done_fire |=> chan_result_reg[$past(conv_chan)] == $past(conv_data))
        else $error("result not stored at its channel");
    a_scan_restart: assert property (
        done_fire && scan_mode && !one_shot && last_ch
        |=> conv_chan == 4'h0 ##1 conv_start)
        else $error("continuous scan did not restart at channel 0");
    a_oneshot_halt: assert property (
        done_fire && one_shot && last_ch && conversion_enable_bit
        |=> !conv_start [*4])
        else $error("one-shot mode kept converting");
    a_select_repeat: assert property (
        done_fire && !scan_mode && !one_shot ##1 conversion_enable_bit |=> conv_start)
        else $error("continuous select did not start again");
    a_mid_scan_quiet: assert property (
        done_fire && !last_ch |-> !end_event ##1 !stat_end || $past(stat_end))
        else $error("event raised before end of scan");
    a_pf_off_event: assert property (
        done_fire && last_ch && !powerfail_enable_bit |=> stat_end)
        else $error("completion without power-fail gave no event");
    a_pf_ge_gate: assert property (
        done_fire && !scan_mode && powerfail_enable_bit && !powerfail_condition_bit
        |-> end_event == (conv_data[9:2] >= powerfail_threshold_reg))
        else $error("greater-equal compare gated wrongly");
    a_pf_lt_gate: assert property (
        done_fire && !scan_mode && powerfail_enable_bit && powerfail_condition_bit
        |-> end_event == (conv_data[9:2] < powerfail_threshold_reg))
        else $error("less-than compare gated wrongly");
    a_irq_follow: assert property (
        end_event ##1 mask_end |=> irq)
        else $error("unmasked event did not raise interrupt");

    c_scan_pass: cover property (done_fire && scan_mode && last_ch && conv_chan != 4'h0);
    c_oneshot_halt: cover property (state == adcsq_pkg::ST_HALT);
    c_pf_suppress: cover property (done_fire && last_ch && powerfail_enable_bit && !end_event);
    c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == `ADCSQ_RESP_SLVERR);
endmodule

//--- dv/tb.sv
// Purpose: self-checking bench for the scan sequencer, register bus and front end
// Assumes: the bench plays the analog front end, answering each start after a fixed delay
// Notes:   every run clears the status first, so each status check sees one run only
`timescale 1ns/1ps
`include "adcsq_cfg.svh"
module tb;
    // ****************************************
    // clock, reset and stimulus signals
    // ****************************************
    localparam int DLY = 20;
    localparam int LIMIT = 40000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic conv_done = 1'b0;
    logic [9:0] conv_data = 10'h000;
    logic awready, wready, bvalid, arready, rvalid, conv_start, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] conv_chan;
    logic [7:0] up_b [16];
    logic [9:0] shadow [16];
    logic [3:0] seq_q [$];
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;

    always #2.5 aclk = ~aclk;

    adcsq_top #(.NCH(16)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data), .irq(irq)
    );

    // ****************************************
    // reporting
    // ****************************************
    task automatic summarize();
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // a hung handshake ends here rather than stalling the run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            summarize();
        end
    end

    // ****************************************
    // front end: answers each start after a delay, data per channel
    // ****************************************
    initial begin
        logic [3:0] ch;
        forever begin
            @(posedge aclk);
            if (conv_start === 1'b1) begin
                ch = conv_chan;
                repeat (DLY - 1) @(posedge aclk);
                conv_data <= {up_b[ch], 2'b10};
                conv_done <= 1'b1;
                seq_q.push_back(ch);
                @(posedge aclk);
                conv_done <= 1'b0;
                conv_data <= ~{up_b[ch], 2'b10}; // stale data never looks valid
            end
        end
    end

    // ****************************************
    // register bus tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        bit ad;
        bit wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("write response", `ADCSQ_RESP_OKAY, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(what, exp, d);
    endtask

    // ****************************************
    // one run of a mode: program, enable, collect, compare
    // ****************************************
    task automatic run(input logic [1:0] mode, input logic [3:0] sel, input logic [1:0] pfm,
                       input logic [7:0] pft, input int nconv, input logic ev,
                       input logic [7:0] base, input logic [7:0] first);
        int i;
        int to;
        logic [3:0] ec;
        for (i = 0; i < 16; i++) begin
            up_b[i] = (i == 0) ? first : base + 8'(i);
        end
        seq_q.delete();
        w(`ADCSQ_CHSEL_OFS, {28'h0, sel});
        w(`ADCSQ_PFM_OFS, {30'h0, pfm});
        w(`ADCSQ_PFT_OFS, {24'h0, pft});
        w(`ADCSQ_STAT_OFS, 32'h1);
        w(`ADCSQ_CTRL_OFS, {29'h0, mode, 1'b1});
        to = 0;
        while (seq_q.size() < nconv && to < 3000) begin
            @(posedge aclk);
            to++;
        end
        // continuous modes run on until the enable is dropped
        if (!mode[1]) w(`ADCSQ_CTRL_OFS, {29'h0, mode, 1'b0});
        repeat (3 * DLY) @(posedge aclk);
        if (mode[1]) chk("conversion count", nconv, seq_q.size());
        for (i = 0; i < nconv; i++) begin
            ec = mode[0] ? 4'(i % (int'(sel) + 1)) : sel;
            chk("channel order", ec, seq_q[i]);
            shadow[ec] = {up_b[ec], 2'b10};
        end
        for (i = 0; i < 16; i++) begin
            rchk("result", 8'h40 + 8'(4 * i), {22'h0, shadow[i]});
        end
        rchk("status", `ADCSQ_STAT_OFS, {31'h0, ev});
        chk("irq", ev, irq);
        if (mode[1]) w(`ADCSQ_CTRL_OFS, {29'h0, mode, 1'b0});
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 16; i++) begin
            shadow[i] = 10'h000;
            up_b[i] = 8'h00;
        end
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // reset values and unmapped places
        rchk("ctrl reset", `ADCSQ_CTRL_OFS, 32'h0);
        rchk("chsel reset", `ADCSQ_CHSEL_OFS, 32'h0);
        rchk("pfm reset", `ADCSQ_PFM_OFS, 32'h0);
        rchk("pft reset", `ADCSQ_PFT_OFS, 32'h0);
        rchk("stat reset", `ADCSQ_STAT_OFS, 32'h0);
        rchk("mask reset", `ADCSQ_MASK_OFS, 32'h0);
        rd(8'hfc, d, r);
        chk("unmapped read resp", `ADCSQ_RESP_SLVERR, r);
        chk("unmapped read data", 32'h0, d);
        wr(8'hfc, 32'h1, r);
        chk("unmapped write resp", `ADCSQ_RESP_SLVERR, r);
        w(`ADCSQ_MASK_OFS, 32'h1);
        // the four modes, power-fail off
        run(2'b11, 4'h3, 2'b00, 8'h00, 4, 1'b1, 8'h10, 8'h05);
        run(2'b10, 4'h5, 2'b00, 8'h00, 1, 1'b1, 8'h20, 8'h06);
        run(2'b01, 4'h2, 2'b00, 8'h00, 7, 1'b1, 8'h30, 8'h07);
        run(2'b00, 4'h7, 2'b00, 8'h00, 3, 1'b1, 8'h40, 8'h08);
        run(2'b11, 4'h0, 2'b00, 8'h00, 1, 1'b1, 8'h50, 8'h09);
        // mask gates the line, status stays; one to status clears it
        w(`ADCSQ_MASK_OFS, 32'h0);
        repeat (3) @(posedge aclk);
        chk("irq masked", 1'b0, irq);
        rchk("status kept", `ADCSQ_STAT_OFS, 32'h1);
        w(`ADCSQ_MASK_OFS, 32'h1);
        repeat (3) @(posedge aclk);
        chk("irq unmasked", 1'b1, irq);
        w(`ADCSQ_STAT_OFS, 32'h1);
        repeat (3) @(posedge aclk);
        chk("irq cleared", 1'b0, irq);
        w(8'h40, 32'h3ff);
        rchk("result read-only", 8'h40, {22'h0, shadow[0]});
        // power-fail one-shot select at the threshold boundary
        run(2'b10, 4'h9, 2'b01, 8'h80, 1, 1'b1, 8'h77, 8'h00);
        run(2'b10, 4'h9, 2'b01, 8'h80, 1, 1'b0, 8'h76, 8'h00);
        run(2'b10, 4'h9, 2'b11, 8'h80, 1, 1'b1, 8'h76, 8'h00);
        run(2'b10, 4'h9, 2'b11, 8'h80, 1, 1'b0, 8'h77, 8'h00);
        run(2'b10, 4'h9, 2'b11, 8'h80, 1, 1'b0, 8'hf6, 8'h00);
        // power-fail scan: channel 0 alone decides; last run is a continuous select of channel 4
        run(2'b11, 4'h2, 2'b01, 8'h80, 3, 1'b0, 8'h90, 8'h7f);
        run(2'b11, 4'h2, 2'b01, 8'h80, 3, 1'b1, 8'h00, 8'h80);
        run(2'b01, 4'h2, 2'b01, 8'h80, 7, 1'b1, 8'h00, 8'h80);
        run(2'b00, 4'h4, 2'b11, 8'h80, 3, 1'b1, 8'h10, 8'h00);
        summarize();
    end
endmodule
